// >>> hw/fe_codec.sv
`timescale 1ns/1ns
module fe_codec
  import codec_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       resetn,
  input  wire logic       link_clk,
  input  wire logic       rmii_mode,
  input  wire logic       encode_en,
  input  wire logic [3:0] txd,
  input  wire logic       tx_en,
  input  wire logic       tx_er,
  output logic      [4:0] sym_out,
  output logic            sym_valid,
  input  wire logic       sym_ready,
  output logic            tx_stall_q,
  input  wire logic [4:0] rx_group,
  input  wire logic       rx_group_valid,
  output logic      [3:0] rxd_q,
  output logic            rxd_valid_q,
  output logic            rx_dv_q,
  output logic            rx_er_q,
  output logic            crs_q
);

  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  // Link inputs are asynchronous to clock and pass two flops before use.
  logic [8:0] meta_q;
  logic [8:0] sync_q;
  logic       link_prev_q;
  logic       phase_q;
  logic       phase_d;
  logic [1:0] low_dibit_q;
  logic [1:0] low_dibit_d;
  tx_state_t  tx_state_q;
  tx_state_t  tx_state_d;
  logic       link_s;
  logic       rmii_s;
  logic       coding;
  logic       en_s;
  logic       er_s;
  logic [3:0] txd_s;
  logic       link_rise;
  logic       nib_evt;
  logic [3:0] nibble;
  logic [4:0] push_data;
  logic       buf_ready;

  assign link_s = sync_q[8];
  assign rmii_s = sync_q[7];
  assign er_s   = sync_q[5];
  assign txd_s  = sync_q[4:1];
  assign en_s   = sync_q[0];
  assign link_rise = link_s && !link_prev_q;
  assign coding    = sync_q[6] || rmii_s; // [R12]

  always_comb
  begin
    phase_d     = phase_q;
    low_dibit_d = low_dibit_q;
    nib_evt     = 1'b0;
    nibble      = txd_s;
    tx_state_d  = tx_state_q;
    push_data   = GROUP_IDLE;
    if (link_rise)
    begin
      if (!rmii_s)
      begin
        nib_evt = 1'b1; // [R02] [R03]
      end
      else if (!phase_q)
      begin
        // Outside a frame every edge carries a slot, so idle, T and R keep flowing.
        low_dibit_d = txd_s[1:0];
        phase_d     = en_s;
        nib_evt     = !en_s; // [R04] [R06] [R08]
      end
      else
      begin
        nib_evt = 1'b1; // [R04]
        nibble  = {txd_s[1:0], low_dibit_q};
        phase_d = 1'b0;
      end
    end
    if (!coding)
    begin
      push_data  = {er_s, nibble}; // [R10] [R11]
      tx_state_d = TX_IDLE;
    end
    else
    begin
      case (tx_state_q)
        TX_IDLE:
        begin
          if (en_s) // [R01]
          begin
            push_data = GROUP_J; // [R07] [R16]
            if (nib_evt)
            begin
              tx_state_d = TX_SSD_K;
            end
          end
          else
          begin
            push_data = GROUP_IDLE; // [R06]
          end
        end
        TX_SSD_K:
        begin
          push_data = GROUP_K; // [R07] [R16]
          if (nib_evt)
          begin
            tx_state_d = TX_DATA;
          end
        end
        TX_DATA:
        begin
          if (!en_s)
          begin
            push_data = GROUP_T; // [R08]
            if (nib_evt)
            begin
              tx_state_d = TX_ESD_R;
            end
          end
          else if (er_s)
          begin
            push_data = GROUP_H; // [R09]
          end
          else
          begin
            push_data = DATA_GROUP[nibble]; // [R05]
          end
        end
        default:
        begin
          push_data = GROUP_R; // [R08]
          if (nib_evt)
          begin
            tx_state_d = TX_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      meta_q      <= 9'h000;
      sync_q      <= 9'h000;
      link_prev_q <= 1'b0;
      phase_q     <= 1'b0;
      low_dibit_q <= 2'h0;
      tx_state_q  <= TX_IDLE;
      tx_stall_q  <= 1'b0;
    end
    else
    begin
      meta_q      <= {link_clk, rmii_mode, encode_en, tx_er, txd, tx_en};
      sync_q      <= meta_q;
      link_prev_q <= link_s;
      phase_q     <= phase_d;
      low_dibit_q <= low_dibit_d;
      tx_state_q  <= tx_state_d;
      tx_stall_q  <= !buf_ready;
    end
  end

  // The line side may pause briefly; two entries cover one stalled symbol slot.
  sym_buffer #(
    .WIDTH (5),
    .DEPTH (2)
  ) u_buffer (
    .clock     (clock),
    .resetn    (resetn),
    .in_data   (push_data),
    .in_valid  (nib_evt),
    .in_ready  (buf_ready),
    .out_data  (sym_out),
    .out_valid (sym_valid),
    .out_ready (sym_ready)
  );

  // Receive checker: groups arrive aligned, at most one every second cycle.
  rx_state_t  rx_state_q;
  rx_state_t  rx_state_d;
  logic [4:0] dec;
  logic       pend_q;
  logic       pend_d;
  logic [3:0] rxd_d;
  logic       rxd_valid_d;
  logic       rx_dv_d;
  logic       rx_er_d;
  logic       crs_d;

  assign dec = decode_group(rx_group);

  always_comb
  begin
    rx_state_d  = rx_state_q;
    pend_d      = 1'b0;
    rxd_d       = rxd_q;
    rxd_valid_d = 1'b0;
    rx_dv_d     = rx_dv_q;
    rx_er_d     = 1'b0;
    crs_d       = crs_q;
    if (pend_q)
    begin
      rxd_d       = NIBBLE_SSD; // [R15]
      rxd_valid_d = 1'b1;
    end
    else if (rx_group_valid)
    begin
      case (rx_state_q)
        RX_IDLE:
        begin
          if (rx_group == GROUP_J)
          begin
            rx_state_d = RX_SSD_K;
            crs_d      = 1'b1;
          end
        end
        RX_SSD_K:
        begin
          rxd_valid_d = 1'b1;
          if (rx_group == GROUP_K)
          begin
            rxd_d      = NIBBLE_SSD; // [R15]
            rx_dv_d    = 1'b1;
            pend_d     = 1'b1;
            rx_state_d = RX_DATA;
          end
          else
          begin
            rxd_d      = NIBBLE_BAD_SSD;
            rx_er_d    = 1'b1;
            crs_d      = 1'b0;
            rx_state_d = RX_IDLE;
          end
        end
        RX_DATA:
        begin
          if (dec[4])
          begin
            rxd_d       = dec[3:0];
            rxd_valid_d = 1'b1;
          end
          else if (rx_group == GROUP_T)
          begin
            rx_state_d = RX_ESD_R;
          end
          else
          begin
            rx_er_d = 1'b1; // [R13] [R14]
          end
        end
        default:
        begin
          if (rx_group == GROUP_R)
          begin
            rx_dv_d    = 1'b0; // [R13]
            crs_d      = 1'b0;
            rx_state_d = RX_IDLE;
          end
          else
          begin
            rx_er_d    = 1'b1; // [R13]
            rx_state_d = RX_DATA;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      rx_state_q  <= RX_IDLE;
      pend_q      <= 1'b0;
      rxd_q       <= 4'h0;
      rxd_valid_q <= 1'b0;
      rx_dv_q     <= 1'b0;
      rx_er_q     <= 1'b0;
      crs_q       <= 1'b0;
    end
    else
    begin
      rx_state_q  <= rx_state_d;
      pend_q      <= pend_d;
      rxd_q       <= rxd_d;
      rxd_valid_q <= rxd_valid_d;
      rx_dv_q     <= rx_dv_d;
      rx_er_q     <= rx_er_d;
      crs_q       <= crs_d;
    end
  end

  AST_MII_CAPTURE: assert property (link_rise && !rmii_s |-> nib_evt) // [R02]
    else $error("MII rising edge did not take a nibble");
  AST_START_PAIR: assert property (nib_evt && coding && tx_state_q == TX_IDLE && en_s
    |-> push_data == GROUP_J ##1 tx_state_q == TX_SSD_K) // [R07]
    else $error("start of frame did not send J then move to K");
  AST_K_SLOT: assert property (nib_evt && coding && tx_state_q == TX_SSD_K
    |-> push_data == GROUP_K) // [R16]
    else $error("second preamble nibble not replaced by K");
  AST_END_PAIR: assert property (nib_evt && coding && tx_state_q == TX_DATA && !en_s
    |-> push_data == GROUP_T ##1 tx_state_q == TX_ESD_R) // [R08]
    else $error("end of frame did not send T");
  AST_IDLE_FILL: assert property (nib_evt && coding && tx_state_q == TX_IDLE && !en_s
    |-> push_data == GROUP_IDLE) // [R06]
    else $error("idle not sent outside a frame");
  AST_DATA_MAP: assert property (nib_evt && coding && tx_state_q == TX_DATA && en_s
    && !sync_q[5] |-> push_data == DATA_GROUP[nibble]) // [R05]
    else $error("data nibble mapped to wrong group");
  AST_ERROR_SYM: assert property (nib_evt && coding && tx_state_q == TX_DATA && en_s
    && sync_q[5] |-> push_data == GROUP_H) // [R09]
    else $error("transmit error did not send H");
  AST_BYPASS: assert property (nib_evt && !coding
    |-> push_data == {sync_q[5], txd_s}) // [R11]
    else $error("bypass word differs from tx_er and txd");
  AST_RMII_CODES: assert property (rmii_s |-> coding) // [R12]
    else $error("bypass active in RMII mode");
  AST_RX_SSD: assert property (rx_group_valid && !pend_q && rx_state_q == RX_SSD_K
    && rx_group == GROUP_K |=> rxd_valid_q && rx_dv_q && rxd_q == NIBBLE_SSD
    ##1 rxd_valid_q && rxd_q == NIBBLE_SSD) // [R15]
    else $error("J K not delivered as two 0101 nibbles");
  AST_RX_ESD: assert property (rx_group_valid && !pend_q && rx_state_q == RX_ESD_R
    && rx_group == GROUP_R |=> !crs_q && !rx_dv_q && !rx_er_q) // [R13]
    else $error("T R did not drop carrier");
  AST_RX_INVALID: assert property (rx_group_valid && !pend_q && rx_state_q == RX_DATA
    && !dec[4] && rx_group != GROUP_T |=> rx_er_q) // [R14]
    else $error("invalid group in frame gave no receive error");

endmodule

// >>> hw/codec_pkg.sv
// Function
// [R01] The MAC holds tx_en high while it drives valid transmit data.
// [R02] In MII mode txd, tx_en and tx_er are taken on each rising link clock edge.
// [R03] In MII mode every transfer carries one 4-bit nibble at 25MHz.
// [R04] In RMII mode transfers are 2-bit dibits at 50MHz, taken on rising edges.
// [R05] Each data nibble 0 to F maps onto its fixed 5-bit data code-group.
// [R06] Outside a frame, and after the end pair, idle 11111 is sent continuously.
// [R07] A rising tx_en sends the start pair 11000 then 10001.
// [R08] A falling tx_en sends the end pair 01101 then 00111.
// [R09] An asserted tx_er during a frame sends 00100 instead of the data group.
// [R10] Clearing the encode enable bypasses the 4B/5B encoder.
// [R11] In bypass tx_er becomes the fifth bit beside the four txd bits.
// [R12] Bypass is allowed in MII mode only, never in RMII mode.
// [R13] On receive, /T/ then /R/ drops carrier; any unpaired /T/ or /R/ flags an error; the code flags them only within a frame and ignores them in RX_IDLE.
// [R14] Any invalid code-group received during a frame flags a receive error.
// [R15] A received /J/K/ pair is delivered as two 0101 nibbles.
// [R16] The start pair replaces the first two preamble nibbles, keeping frame length.
package codec_pkg;

  localparam logic [4:0] GROUP_IDLE = 5'h1f;
  localparam logic [4:0] GROUP_J    = 5'h18;
  localparam logic [4:0] GROUP_K    = 5'h11;
  localparam logic [4:0] GROUP_T    = 5'h0d;
  localparam logic [4:0] GROUP_R    = 5'h07;
  localparam logic [4:0] GROUP_H    = 5'h04;
  localparam logic [3:0] NIBBLE_SSD = 4'h5;
  localparam logic [3:0] NIBBLE_BAD_SSD = 4'he;

  localparam logic [4:0] DATA_GROUP [16] = '{
    5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b, 5'h0e, 5'h0f,
    5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d
  };

  typedef enum logic [1:0] {TX_IDLE, TX_SSD_K, TX_DATA, TX_ESD_R} tx_state_t;
  typedef enum logic [1:0] {RX_IDLE, RX_SSD_K, RX_DATA, RX_ESD_R} rx_state_t;

  // Returns the data flag in bit 4 and the nibble below it.
  function automatic logic [4:0] decode_group(input logic [4:0] group);
    logic [4:0] result;
    result = 5'h00;
    for (int i = 0; i < 16; i++)
    begin
      if (DATA_GROUP[i] == group)
      begin
        result = {1'b1, 4'(i)};
      end
    end
    return result;
  endfunction

endpackage

// >>> hw/sym_buffer.sv
`timescale 1ns/1ns
module sym_buffer
  import codec_pkg::*;
#(
  parameter int WIDTH = 5,
  parameter int DEPTH = 2
)(
  input  wire logic             clock,
  input  wire logic             resetn,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);

  if (DEPTH != 2)
  begin : g_depth_check
    $error("sym_buffer holds exactly two entries");
  end

  logic [WIDTH-1:0] head_q;
  logic [WIDTH-1:0] head_d;
  logic [WIDTH-1:0] tail_q;
  logic [WIDTH-1:0] tail_d;
  logic             head_v_q;
  logic             head_v_d;
  logic             tail_v_q;
  logic             tail_v_d;

  assign in_ready  = !tail_v_q;
  assign out_data  = head_q;
  assign out_valid = head_v_q;

  // The head always drives the output, so a pop only shifts the tail forward.
  always_comb
  begin
    head_d   = head_q;
    tail_d   = tail_q;
    head_v_d = head_v_q;
    tail_v_d = tail_v_q;
    if (head_v_q && out_ready)
    begin
      head_d   = tail_q;
      head_v_d = tail_v_q;
      tail_v_d = 1'b0;
    end
    if (in_valid && !tail_v_q)
    begin
      if (!head_v_d)
      begin
        head_d   = in_data;
        head_v_d = 1'b1;
      end
      else
      begin
        tail_d   = in_data;
        tail_v_d = 1'b1;
      end
    end
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      head_q   <= '0;
      tail_q   <= '0;
      head_v_q <= 1'b0;
      tail_v_q <= 1'b0;
    end
    else
    begin
      head_q   <= head_d;
      tail_q   <= tail_d;
      head_v_q <= head_v_d;
      tail_v_q <= tail_v_d;
    end
  end

endmodule

// >>> hw/_unused_guard.sv
`timescale 1ns/1ns

// >>> sim/mac_model.sv
`timescale 1ns/1ns
module mac_model (
  input  wire logic       clock,
  input  wire logic       rmii_mode,
  output logic            link_clk,
  output logic      [3:0] txd,
  output logic            tx_en,
  output logic            tx_er
);
  // The reference clock runs free, offset so that its edges never meet the system clock's.
  initial
  begin
    link_clk = 1'b0;
    #7;
    forever #200 link_clk = ~link_clk;
  end

  initial
  begin
    txd = 4'h0;
    tx_en = 1'b0;
    tx_er = 1'b0;
  end

  // Changes after a falling link edge and holds until the next rising edge.
  task automatic put(input logic en, input logic er, input logic [3:0] d);
    @(negedge link_clk);
    @(negedge clock);
    tx_en = en;
    tx_er = er;
    txd = en ? d : ~txd;
  endtask

  // Words are {tx_er, nibble}; RMII sends the low dibit first.
  task automatic frame(input logic [4:0] w[$]);
    foreach (w[i])
    begin
      if (rmii_mode)
      begin
        put(1'b1, w[i][4], {2'h0, w[i][1:0]});
        put(1'b1, w[i][4], {2'h0, w[i][3:2]});
      end
      else
        put(1'b1, w[i][4], w[i][3:0]);
    end
    put(1'b0, 1'b0, 4'h0);
  endtask
endmodule

// >>> sim/test_fast_ethernet_tx_4b5b_encoder.sv
`timescale 1ns/1ns
module test_fast_ethernet_tx_4b5b_encoder
  import codec_pkg::*;
();
  localparam logic [4:0] CODE [16] = '{5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b, 5'h0e,
    5'h0f, 5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d};
  logic       clock;
  logic       resetn;
  logic       link_clk;
  logic       rmii_mode;
  logic       encode_en;
  logic [3:0] txd;
  logic       tx_en;
  logic       tx_er;
  logic [4:0] sym_out;
  logic       sym_valid;
  logic       sym_ready;
  logic       tx_stall_q;
  logic [4:0] rx_group;
  logic       rx_group_valid;
  logic [3:0] rxd_q;
  logic       rxd_valid_q;
  logic       rx_dv_q;
  logic       rx_er_q;
  logic       crs_q;
  logic [4:0] got[$];
  logic [3:0] rxq[$];
  int         rx_errs;
  int         miscompares;
  int         checks_done;

  fe_codec dut_u (.clock(clock), .resetn(resetn), .link_clk(link_clk), .rmii_mode(rmii_mode),
    .encode_en(encode_en), .txd(txd), .tx_en(tx_en), .tx_er(tx_er), .sym_out(sym_out),
    .sym_valid(sym_valid), .sym_ready(sym_ready), .tx_stall_q(tx_stall_q),
    .rx_group(rx_group), .rx_group_valid(rx_group_valid), .rxd_q(rxd_q),
    .rxd_valid_q(rxd_valid_q), .rx_dv_q(rx_dv_q), .rx_er_q(rx_er_q), .crs_q(crs_q));
  mac_model mac_u (.clock(clock), .rmii_mode(rmii_mode), .link_clk(link_clk), .txd(txd),
    .tx_en(tx_en), .tx_er(tx_er));

  initial
  begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  always @(posedge clock)
  begin
    if (sym_valid === 1'b1 && sym_ready === 1'b1)
      got.push_back(sym_out);
    if (rxd_valid_q === 1'b1)
      rxq.push_back(rxd_q);
    if (rx_er_q === 1'b1)
      rx_errs++;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    checks_done++;
    if (seen !== want)
    begin
      miscompares++;
      $display("CHECK FAILED t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask

  task automatic complete_run;
    $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Aligns on the first expected word, since idle groups of unknown count come before it.
  task automatic match(input logic [4:0] exp[$]);
    int k;
    k = 0;
    while (k < got.size() && got[k] !== exp[0])
      k++;
    foreach (exp[i])
      check(k + i < got.size() ? got[k + i] : 5'bx, exp[i]);
  endtask

  task automatic setup(input logic rmii, input logic enc);
    @(negedge clock);
    rmii_mode = rmii;
    encode_en = enc;
    repeat (40) @(negedge clock);
    got.delete();
  endtask

  // Sends a frame with preamble 5 5 and all sixteen nibbles, nibble 9 sent with tx_er set.
  task automatic coded_frame(input logic rmii);
    logic [4:0] w[$];
    logic [4:0] exp[$];
    setup(rmii, !rmii);
    w = '{5'h05, 5'h05};
    exp = '{GROUP_J, GROUP_K};
    for (int i = 0; i < 16; i++)
    begin
      w.push_back({i == 9, 4'(i)});
      exp.push_back(i == 9 ? GROUP_H : CODE[i]);
    end
    exp.push_back(GROUP_T);
    exp.push_back(GROUP_R);
    exp.push_back(GROUP_IDLE);
    exp.push_back(GROUP_IDLE);
    mac_u.frame(w);
    repeat (100) @(negedge clock);
    match(exp);
  endtask

  task automatic bypass_frame;
    setup(1'b0, 1'b0);
    mac_u.frame('{5'h00, 5'h00, 5'h1f, 5'h10, 5'h0f, 5'h15, 5'h0a});
    repeat (60) @(negedge clock);
    match('{5'h1f, 5'h10, 5'h0f, 5'h15, 5'h0a, 5'h05});
  endtask

  // A stalled receiver fills both entries; the idle word must survive the stall.
  task automatic stall_test;
    setup(1'b0, 1'b1);
    sym_ready = 1'b0;
    repeat (40) @(negedge clock);
    check(tx_stall_q, 1'b1);
    check(sym_out, GROUP_IDLE);
    sym_ready = 1'b1;
    repeat (20) @(negedge clock);
    check(tx_stall_q, 1'b0);
  endtask

  task automatic grp(input logic [4:0] g);
    @(negedge clock);
    rx_group = g;
    rx_group_valid = 1'b1;
    @(negedge clock);
    rx_group_valid = 1'b0;
    repeat (3) @(negedge clock);
  endtask

  task automatic rx_test;
    rxq.delete();
    rx_errs = 0;
    grp(GROUP_J);
    grp(GROUP_K);
    check(rx_dv_q, 1'b1);
    for (int i = 0; i < 16; i++)
      grp(CODE[i]);
    grp(GROUP_T);
    grp(GROUP_R);
    check(crs_q, 1'b0);
    check(rx_dv_q, 1'b0);
    for (int i = 0; i < 18; i++)
      check(rxq.size() > i ? rxq[i] : 4'bx, i < 2 ? 4'h5 : 4'(i - 2));
    check(8'(rx_errs), 8'h00);
    grp(GROUP_J);
    grp(5'h00);
    check(rxd_q, 4'he);
    check(crs_q, 1'b0);
    check(8'(rx_errs), 8'h01);
    rx_errs = 0;
    grp(GROUP_J);
    grp(GROUP_K);
    grp(5'h00);
    grp(5'h06);
    grp(5'h19);
    check(8'(rx_errs), 8'h03);
    grp(GROUP_T);
    grp(5'h1e);
    grp(GROUP_R);
    check(8'(rx_errs), 8'h05);
    grp(GROUP_T);
    grp(GROUP_R);
    check(crs_q, 1'b0);
  endtask

  initial
  begin
    repeat (30000) @(posedge clock);
    miscompares++;
    complete_run();
  end

  initial
  begin
    resetn = 1'b0;
    rmii_mode = 1'b0;
    encode_en = 1'b1;
    sym_ready = 1'b1;
    rx_group = 5'h00;
    rx_group_valid = 1'b0;
    repeat (12) @(negedge clock);
    resetn = 1'b1;
    coded_frame(1'b0);
    coded_frame(1'b1);
    bypass_frame();
    stall_test();
    rx_test();
    complete_run();
  end
endmodule
